/* logic/sfel_core.sv */
`timescale 1ns/100ps
// Notes on behaviour
// RQ1 - Level zero frame creation copies no earlier frame pointers.
// RQ2 - First display doubleword is the frame base held before the instruction.
// RQ3 - At level one the new frame base is written as second doubleword.
// RQ4 - Afterwards frame base points at first push, stack pointer at frame end.
// RQ5 - Deeper levels copy caller display pointers in order after saved frame base.
// RQ6 - Push pointer to the new frame at every nonzero level; omit at level zero.
// RQ7 - Release takes no operands and first copies frame base into stack pointer.
// RQ8 - Release then pops saved frame base, restoring stack pointer.
// RQ9 - Eight 32-bit general registers.
// RQ10 - Six 16-bit segment registers.
// RQ11 - A 32-bit flags register.
// RQ12 - A 32-bit instruction pointer register.
// RQ13 - Lexical level operand accepted from zero through thirty-one.
// RQ14 - Level zero: push frame base, copy stack pointer, subtract storage.
// RQ15 - After the display, stack pointer drops by the storage byte count.
// RQ16 - Stack pointer drops four before each push; display writes in order.
module sfel_core (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // Instruction request
    input wire logic i_req_valid,
    input wire sfel_pkg::sfel_req_s i_req,
    output logic o_req_ready,
    output logic o_done,
    // Stack memory
    output sfel_pkg::sfel_mem_s o_mem,
    input wire logic i_mem_ack,
    input wire logic [31:0] i_mem_rdata,
    // Architectural state view
    output logic [31:0] o_stack_ptr,
    output logic [31:0] o_frame_base,
    output logic [31:0] o_flags,
    output logic [31:0] o_instr_ptr,
    output logic [15:0] o_data_seg
);
    // Create runs: saved base push, read and write pairs, pointer push, allocation;
    // release runs a single pop
    typedef enum {
        ST_IDLE,
        ST_PUSH_FB,
        ST_RD_DISP,
        ST_WR_DISP,
        ST_PUSH_CUR,
        ST_ALLOC,
        ST_POP_FB,
        ST_DONE
    } sfel_state_e;

    sfel_state_e state_r;

    // Architectural register file and state
    logic [31:0] gp_r [sfel_pkg::NUM_GP];
    logic [15:0] seg_r [sfel_pkg::NUM_SEG];
    logic [31:0] flags_r;
    logic [31:0] ip_r;

    // Working registers for the running create or release
    logic [31:0] old_fb_r;
    logic [31:0] frame_tmp_r;
    logic [31:0] copy_val_r;
    logic [4:0] level_r;
    logic [4:0] cnt_r;
    logic [15:0] storage_r;
    logic [31:0] rd_ptr_r;
    sfel_pkg::sfel_mem_s mem_r;
    logic done_r;
    logic ready_r;

    // One doubleword below a pointer; every push steps down by this
    function automatic logic [31:0] dec_dw(input logic [31:0] v);
        dec_dw = v - sfel_pkg::DWORD_BYTES;
    endfunction

    // Elaboration checks: the views, arrays and index fields assume these sizes
    if (sfel_pkg::DWORD_W != 32 || sfel_pkg::SEG_W != 16) begin : g_bad_width
        $error("sfel_core: register widths must be 32 and 16 bits");
    end
    if (sfel_pkg::NUM_GP != 8 || sfel_pkg::NUM_SEG != 6) begin : g_bad_count
        $error("sfel_core: eight general and six segment registers expected");
    end
    // Levels zero to thirty-one fill exactly five operand bits
    if (sfel_pkg::LEVEL_W != 5) begin : g_bad_level
        $error("sfel_core: level operand must be five bits wide");
    end

    // Create and release run the sequencer; everything else finishes at once
    function automatic logic is_long_op(input sfel_pkg::sfel_op_e op);
        is_long_op = (op == sfel_pkg::SFEL_OP_ENTER) || (op == sfel_pkg::SFEL_OP_LEAVE);
    endfunction

    // Ready has its own flop so the requester sees no decode path;
    // it mirrors the idle state one for one
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ready_r <= 1'b1;
        end else if (state_r == ST_IDLE) begin
            // Any level operand is taken; five bits cover zero to thirty-one
            ready_r <= !(i_req_valid && is_long_op(i_req.op)); // see RQ13
        end else begin
            // Only the last state of a sequence returns to idle
            ready_r <= (state_r == ST_DONE);
        end
    end

    // Sequencer plus stack and frame registers
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r <= ST_IDLE;
            for (int i = 0; i < sfel_pkg::NUM_GP; i++) begin
                gp_r[i] <= 32'h0000_0000;
            end
            old_fb_r <= 32'h0000_0000;
            frame_tmp_r <= 32'h0000_0000;
            copy_val_r <= 32'h0000_0000;
            level_r <= 5'h00;
            cnt_r <= 5'h00;
            storage_r <= 16'h0000;
            rd_ptr_r <= 32'h0000_0000;
            mem_r <= '0;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (i_req_valid) begin
                        case (i_req.op)
                            sfel_pkg::SFEL_OP_ENTER: begin
                                // Capture frame base before anything moves
                                old_fb_r <= gp_r[sfel_pkg::GP_FB]; // see RQ2
                                level_r <= i_req.level;
                                storage_r <= i_req.storage;
                                gp_r[sfel_pkg::GP_SP] <= dec_dw(gp_r[sfel_pkg::GP_SP]); // see RQ16
                                mem_r.req <= 1'b1;
                                mem_r.wr <= 1'b1;
                                mem_r.addr <= dec_dw(gp_r[sfel_pkg::GP_SP]);
                                mem_r.wdata <= gp_r[sfel_pkg::GP_FB]; // see RQ2
                                state_r <= ST_PUSH_FB;
                            end
                            sfel_pkg::SFEL_OP_LEAVE: begin
                                // Operands ignored; drop locals first
                                gp_r[sfel_pkg::GP_SP] <= gp_r[sfel_pkg::GP_FB]; // see RQ7
                                mem_r.req <= 1'b1;
                                mem_r.wr <= 1'b0;
                                mem_r.addr <= gp_r[sfel_pkg::GP_FB];
                                state_r <= ST_POP_FB;
                            end
                            sfel_pkg::SFEL_OP_WRREG: begin
                                // Plain register write; finishes in one cycle
                                gp_r[i_req.reg_sel] <= i_req.reg_data; // see RQ9
                                done_r <= 1'b1;
                            end
                            default: begin
                                done_r <= 1'b1;
                            end
                        endcase
                    end
                end
                ST_PUSH_FB: begin
                    if (i_mem_ack) begin
                        mem_r.req <= 1'b0;
                        frame_tmp_r <= gp_r[sfel_pkg::GP_SP];
                        rd_ptr_r <= old_fb_r;
                        cnt_r <= 5'h01;
                        // Level zero: no display and no pointer pushes
                        if (level_r == 5'h00) begin
                            state_r <= ST_ALLOC; // see RQ1 RQ14
                        end else if (level_r == 5'h01) begin
                            state_r <= ST_PUSH_CUR;
                        end else begin
                            state_r <= ST_RD_DISP;
                        end
                    end
                end
                ST_RD_DISP: begin
                    // Fetch the caller display entries one at a time
                    if (!mem_r.req) begin
                        mem_r.req <= 1'b1;
                        mem_r.wr <= 1'b0;
                        mem_r.addr <= dec_dw(rd_ptr_r);
                        rd_ptr_r <= dec_dw(rd_ptr_r);
                    end else if (i_mem_ack) begin
                        mem_r.req <= 1'b0;
                        copy_val_r <= i_mem_rdata;
                        state_r <= ST_WR_DISP;
                    end
                end
                ST_WR_DISP: begin
                    // Reads and writes alternate, so the display stays ordered
                    if (!mem_r.req) begin
                        gp_r[sfel_pkg::GP_SP] <= dec_dw(gp_r[sfel_pkg::GP_SP]); // see RQ16
                        mem_r.req <= 1'b1;
                        mem_r.wr <= 1'b1;
                        mem_r.addr <= dec_dw(gp_r[sfel_pkg::GP_SP]);
                        mem_r.wdata <= copy_val_r; // see RQ5
                    end else if (i_mem_ack) begin
                        mem_r.req <= 1'b0;
                        cnt_r <= cnt_r + 5'h01;
                        if (cnt_r + 5'h01 == level_r) begin
                            state_r <= ST_PUSH_CUR;
                        end else begin
                            state_r <= ST_RD_DISP;
                        end
                    end
                end
                ST_PUSH_CUR: begin
                    // Pointer to the new frame, which is the caller's view;
                    // same-level callers never reach here with a deeper level
                    if (!mem_r.req) begin
                        gp_r[sfel_pkg::GP_SP] <= dec_dw(gp_r[sfel_pkg::GP_SP]); // see RQ16
                        mem_r.req <= 1'b1;
                        mem_r.wr <= 1'b1;
                        mem_r.addr <= dec_dw(gp_r[sfel_pkg::GP_SP]);
                        mem_r.wdata <= frame_tmp_r; // see RQ3 RQ6
                    end else if (i_mem_ack) begin
                        mem_r.req <= 1'b0;
                        state_r <= ST_ALLOC;
                    end
                end
                ST_ALLOC: begin
                    // Frame base at first push, stack at end of locals
                    gp_r[sfel_pkg::GP_FB] <= frame_tmp_r; // see RQ4 RQ14
                    gp_r[sfel_pkg::GP_SP] <= gp_r[sfel_pkg::GP_SP]
                        - {16'h0000, storage_r}; // see RQ15
                    done_r <= 1'b1;
                    state_r <= ST_DONE;
                end
                ST_POP_FB: begin
                    if (i_mem_ack) begin
                        mem_r.req <= 1'b0;
                        // Popped word becomes the frame base; stack back to pre-call
                        gp_r[sfel_pkg::GP_FB] <= i_mem_rdata; // see RQ8
                        gp_r[sfel_pkg::GP_SP] <= gp_r[sfel_pkg::GP_SP]
                            + sfel_pkg::DWORD_BYTES; // see RQ8
                        done_r <= 1'b1;
                        state_r <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    // Gap cycle so the next request meets settled views
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Segment registers, written only while idle
    // An index above the last segment is dropped, not wrapped
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int i = 0; i < sfel_pkg::NUM_SEG; i++) begin
                seg_r[i] <= 16'h0000;
            end
        end else if (i_req_valid && state_r == ST_IDLE && i_req.seg_wr
                     && i_req.seg_sel <= sfel_pkg::SEG_LAST) begin
            seg_r[i_req.seg_sel] <= i_req.reg_data[15:0]; // see RQ10
        end
    end

    // Flags register
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            flags_r <= sfel_pkg::RST_FLAGS;
        end else if (i_req_valid && state_r == ST_IDLE && i_req.flags_wr) begin
            flags_r <= i_req.flags_data; // see RQ11
        end
    end

    // Instruction pointer advances on each accepted instruction
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ip_r <= sfel_pkg::RST_IP;
        end else if (i_req_valid && state_r == ST_IDLE) begin
            ip_r <= i_req.next_ip; // see RQ12
        end
    end

    // Registered outputs
    // Views lag the registers by one cycle; callers wait past done
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_stack_ptr <= sfel_pkg::RST_STACK;
            o_frame_base <= 32'h0000_0000;
            o_flags <= sfel_pkg::RST_FLAGS;
            o_instr_ptr <= sfel_pkg::RST_IP;
            o_data_seg <= 16'h0000;
        end else begin
            o_stack_ptr <= gp_r[sfel_pkg::GP_SP];
            o_frame_base <= gp_r[sfel_pkg::GP_FB];
            o_flags <= flags_r;
            o_instr_ptr <= ip_r;
            o_data_seg <= seg_r[sfel_pkg::SEG_DATA];
        end
    end

    // Outputs straight from their flops
    assign o_mem = mem_r;
    assign o_done = done_r;
    assign o_req_ready = ready_r;
endmodule

/* logic/sfel_pkg.sv */
package sfel_pkg;
    localparam int unsigned DWORD_W = 32;
    localparam int unsigned SEG_W = 16;
    localparam int unsigned NUM_GP = 8;
    localparam int unsigned NUM_SEG = 6;
    localparam int unsigned LEVEL_W = 5;
    localparam logic [31:0] DWORD_BYTES = 32'h0000_0004;
    localparam logic [31:0] RST_STACK = 32'h0000_0000;
    localparam logic [31:0] RST_FLAGS = 32'h0000_0002;
    localparam logic [31:0] RST_IP = 32'h0000_0000;
    // General register indices
    localparam logic [2:0] GP_A = 3'h0;
    localparam logic [2:0] GP_C = 3'h1;
    localparam logic [2:0] GP_D = 3'h2;
    localparam logic [2:0] GP_B = 3'h3;
    localparam logic [2:0] GP_SP = 3'h4;
    localparam logic [2:0] GP_FB = 3'h5;
    localparam logic [2:0] GP_SI = 3'h6;
    localparam logic [2:0] GP_DI = 3'h7;
    // Segment register indices: data segment view and the last one fitted
    localparam logic [2:0] SEG_DATA = 3'h3;
    localparam logic [2:0] SEG_LAST = 3'h5;

    typedef enum logic [1:0] {
        SFEL_OP_NONE,
        SFEL_OP_ENTER,
        SFEL_OP_LEAVE,
        SFEL_OP_WRREG
    } sfel_op_e;

    // Instruction request from the decoder
    typedef struct packed {
        sfel_op_e op;
        logic [15:0] storage;
        logic [4:0] level;
        logic [2:0] reg_sel;
        logic [31:0] reg_data;
        logic seg_wr;
        logic [2:0] seg_sel;
        logic [31:0] next_ip;
        logic flags_wr;
        logic [31:0] flags_data;
    } sfel_req_s;

    // Stack memory request
    typedef struct packed {
        logic req;
        logic wr;
        logic [31:0] addr;
        logic [31:0] wdata;
    } sfel_mem_s;
endpackage

/* testbench/sfel_stack_mem.sv */
`timescale 1ns/100ps
module sfel_stack_mem (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // Stack memory port
    input wire sfel_pkg::sfel_mem_s i_mem,
    input wire logic [3:0] i_wait,
    output logic o_ack,
    output logic [31:0] o_rdata
);
    logic [31:0] ram [0:1023];
    logic [3:0] cnt_r;
    logic [31:0] last_r;

    // Ack after i_wait idle cycles; a slow setting stretches the hold
    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_r <= 4'h0;
            o_ack <= 1'b0;
            last_r <= 32'h0;
        end else if (i_mem.req && !o_ack && cnt_r >= i_wait) begin
            o_ack <= 1'b1;
            cnt_r <= 4'h0;
            if (i_mem.wr) begin
                ram[i_mem.addr[11:2]] <= i_mem.wdata;
            end else begin
                last_r <= ram[i_mem.addr[11:2]];
            end
        end else begin
            o_ack <= 1'b0;
            cnt_r <= (i_mem.req && !o_ack) ? cnt_r + 4'h1 : 4'h0;
        end
    end

    // Outside the ack cycle the data lines show junk, not the last word
    assign o_rdata = o_ack ? last_r : ~last_r;
endmodule

/* testbench/sfel_core_checker.sv */
`timescale 1ns/100ps
module sfel_core_checker (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // Request and memory
    input wire logic i_req_valid,
    input wire sfel_pkg::sfel_req_s i_req,
    input wire logic o_req_ready,
    input wire logic o_done,
    input wire sfel_pkg::sfel_mem_s o_mem,
    input wire logic i_mem_ack,
    input wire logic [31:0] i_mem_rdata,
    // State views
    input wire logic [31:0] o_stack_ptr,
    input wire logic [31:0] o_frame_base
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_resetn);
    logic take;
    logic [5:0] nw;
    logic [4:0] lvl;
    logic [15:0] stor;
    logic [1:0] op;
    logic [31:0] fw, lw, rd, ra;
    assign take = i_req_valid && o_req_ready;

    // Operands and write history of the running instruction
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            nw <= 6'h00;
            {lvl, stor, op, fw, lw} <= '0;
        end else if (take) begin
            nw <= 6'h00;
            {lvl, stor, op} <= {i_req.level, i_req.storage, i_req.op};
        end else if (o_mem.req && o_mem.wr && i_mem_ack) begin
            nw <= nw + 6'h01;
            lw <= o_mem.addr;
            fw <= (nw == 6'h00) ? o_mem.addr : fw;
        end
    end

    // Word popped by a release
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            {rd, ra} <= '0;
        end else if (o_mem.req && !o_mem.wr && i_mem_ack) begin
            {rd, ra} <= {i_mem_rdata, o_mem.addr};
        end
    end

    sequence s_enter;
        take && i_req.op == sfel_pkg::SFEL_OP_ENTER;
    endsequence
    sequence s_leave;
        take && i_req.op == sfel_pkg::SFEL_OP_LEAVE;
    endsequence

    AST_DONE_PULSE: assert property (o_done |=> !o_done)
        else $error("done pulse longer than one cycle");
    AST_MEM_HOLD: assert property (
        o_mem.req && !i_mem_ack |=> o_mem.req && $stable(o_mem))
        else $error("memory request changed before ack");
    AST_FIRST_PUSH: assert property (s_enter |=> o_mem.req && o_mem.wr &&
        o_mem.addr == $past(o_stack_ptr) - 32'h4 && o_mem.wdata == $past(o_frame_base))
        else $error("first push wrong");
    AST_PUSH_DESC: assert property (
        o_mem.req && o_mem.wr && nw != 6'h00 |-> o_mem.addr == lw - 32'h4)
        else $error("pushes not descending by four");
    AST_WR_COUNT: assert property (o_done && op == 2'h1 |->
        nw == ((lvl == 5'h00) ? 6'h01 : {1'b0, lvl} + 6'h01))
        else $error("wrong number of display pushes");
    AST_ENTER_END: assert property (o_done && op == 2'h1 |-> ##[1:2]
        (o_frame_base == fw && o_stack_ptr == lw - {16'h0, stor}))
        else $error("frame base or stack pointer wrong after create");
    AST_LEAVE_READ: assert property (s_leave |=> o_mem.req && !o_mem.wr &&
        o_mem.addr == $past(o_frame_base))
        else $error("release did not pop at frame base");
    AST_LEAVE_END: assert property (o_done && op == 2'h2 |-> ##[1:2]
        (o_frame_base == rd && o_stack_ptr == ra + 32'h4))
        else $error("release did not restore registers");
endmodule

bind sfel_core sfel_core_checker u_chk (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_req_valid(i_req_valid),
    .i_req(i_req), .o_req_ready(o_req_ready), .o_done(o_done), .o_mem(o_mem),
    .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata), .o_stack_ptr(o_stack_ptr),
    .o_frame_base(o_frame_base)
);

/* testbench/stack_frame_enter_leave_tb.sv */
`timescale 1ns/100ps
module stack_frame_enter_leave_tb;
    logic i_core_clk, i_resetn, i_req_valid, i_mem_ack, o_req_ready, o_done;
    sfel_pkg::sfel_req_s i_req;
    sfel_pkg::sfel_mem_s o_mem;
    logic [31:0] i_mem_rdata, o_stack_ptr, o_frame_base, o_flags, o_instr_ptr;
    logic [15:0] o_data_seg;
    logic [3:0] mem_wait;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;

    sfel_core dut (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_req_valid(i_req_valid),
        .i_req(i_req), .o_req_ready(o_req_ready), .o_done(o_done), .o_mem(o_mem),
        .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata), .o_stack_ptr(o_stack_ptr),
        .o_frame_base(o_frame_base), .o_flags(o_flags), .o_instr_ptr(o_instr_ptr),
        .o_data_seg(o_data_seg));
    sfel_stack_mem u_mem (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_mem(o_mem),
        .i_wait(mem_wait), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));

    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One request; done is sampled at negedge to stay clear of the edge
    task automatic send(input sfel_pkg::sfel_req_s r);
        int n;
        n = 0;
        i_req <= r;
        i_req_valid <= 1'b1;
        @(posedge i_core_clk);
        i_req_valid <= 1'b0;
        do begin
            @(negedge i_core_clk);
            n++;
        end while (o_done !== 1'b1 && n < 2000);
        if (n >= 2000) fails++;
        repeat (3) @(posedge i_core_clk);
    endtask

    task automatic wreg(input logic [2:0] sel, input logic [31:0] d);
        sfel_pkg::sfel_req_s r;
        r = '0;
        r.op = sfel_pkg::SFEL_OP_WRREG;
        r.reg_sel = sel;
        r.reg_data = d;
        send(r);
    endtask

    task automatic check_env();
        sfel_pkg::sfel_req_s r;
        r = '0;
        r.op = sfel_pkg::SFEL_OP_WRREG;
        r.reg_data = 32'h1234_abcd;
        {r.seg_wr, r.seg_sel, r.flags_wr} = {1'b1, 3'h3, 1'b1};
        r.flags_data = 32'h0000_0ad7;
        r.next_ip = 32'h0040_1000;
        send(r);
        chk("data_seg", 32'h0000_abcd, {16'h0, o_data_seg});
        chk("flags", 32'h0000_0ad7, o_flags);
        chk("instr_ptr", 32'h0040_1000, o_instr_ptr);
        // Empty operation: only the instruction pointer moves
        r = '0;
        r.op = sfel_pkg::SFEL_OP_NONE;
        r.next_ip = 32'h0040_1004;
        send(r);
        chk("ip_none", 32'h0040_1004, o_instr_ptr);
        chk("flags_none", 32'h0000_0ad7, o_flags);
        wreg(sfel_pkg::GP_FB, 32'hfedc_ba98);
        chk("frame_base", 32'hfedc_ba98, o_frame_base);
    endtask

    // Create then release; caller display seeded at f, new frame built below s
    task automatic run_enter(input logic [4:0] lvl, input logic [15:0] st, input logic [3:0] w);
        sfel_pkg::sfel_req_s r;
        logic [31:0] f, s, e;
        int cnt;
        f = 32'h0000_0800;
        s = 32'h0000_0600;
        cnt = (lvl == 5'h00) ? 1 : lvl + 1;
        mem_wait <= w;
        wreg(sfel_pkg::GP_SP, s);
        wreg(sfel_pkg::GP_FB, f);
        for (int k = 0; k < 40; k++) begin
            u_mem.ram[(f >> 2) - k] = 32'hc0de_0000 + k;
            u_mem.ram[(s >> 2) - k] = 32'h0;
        end
        r = '0;
        r.op = sfel_pkg::SFEL_OP_ENTER;
        r.level = lvl;
        r.storage = st;
        send(r);
        for (int k = 0; k < cnt; k++) begin
            e = (k == 0) ? f : (k == lvl) ? s - 32'h4 : 32'hc0de_0000 + k;
            chk("display", e, u_mem.ram[(s >> 2) - k - 1]);
        end
        chk("enter_fb", s - 32'h4, o_frame_base);
        chk("enter_sp", s - 32'h4 * cnt - {16'h0, st}, o_stack_ptr);
        // Operand fields left set: release must ignore them
        r.op = sfel_pkg::SFEL_OP_LEAVE;
        send(r);
        chk("leave_fb", f, o_frame_base);
        chk("leave_sp", s, o_stack_ptr);
    endtask

    // Reset in mid-run: stack, frame base, flags and pointer views and ready return to reset values, then a create works
    task automatic reset_mid();
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        i_resetn <= 1'b1;
        @(negedge i_core_clk);
        chk("sp_rst", sfel_pkg::RST_STACK, o_stack_ptr);
        chk("fb_rst", 32'h0000_0000, o_frame_base);
        chk("flags_rst2", sfel_pkg::RST_FLAGS, o_flags);
        chk("ip_rst", sfel_pkg::RST_IP, o_instr_ptr);
        chk("ready_rst2", 32'h0000_0001, {31'h0, o_req_ready});
        @(posedge i_core_clk);
        run_enter(5'h03, 16'h0008, 4'h1);
    endtask

    initial begin
        i_resetn = 1'b0;
        i_req_valid = 1'b0;
        i_req = '0;
        mem_wait = 4'h0;
        repeat (8) @(posedge i_core_clk);
        i_resetn <= 1'b1;
        @(posedge i_core_clk);
        chk("flags_rst", 32'h0000_0002, o_flags);
        chk("ready_rst", 32'h0000_0001, {31'h0, o_req_ready});
        check_env();
        run_enter(5'h00, 16'h0010, 4'h0);
        run_enter(5'h01, 16'h0000, 4'h3);
        run_enter(5'h02, 16'h0020, 4'h0);
        run_enter(5'h05, 16'h0004, 4'h2);
        run_enter(5'h1f, 16'hffff, 4'h1);
        reset_mid();
        test_done();
    end
endmodule
